// >>> pkg/acv_map.svh
// Operation
// [R1] reference field picks supply, pin, internal, capacitor
// [R2] reference/channel changes held until conversion completes
// [R3] software discards first result after reference change
// [R4] no internal reference with external pin driven
// [R5] left-align bit reformats result view immediately
// [R6] codes 0-10 single-ended, 30 bandgap, 31 ground
// [R7] differential codes drive pos, neg, gain per table
// [R8] same-input 20x codes supported for offset
// [R9] enable powers up; clearing aborts conversion
// [R10] single needs start each time; free-run continues
// [R11] first start after enable runs dummy conversion
// [R12] start reads one until real conversion done
// [R13] writing zero to start has no effect
// [R14] free-run bit samples continuously; clearing ends it
// [R15] flag set when result registers updated
// [R16] flag cleared by vector taken or writing one
// [R17] interrupt requested when flag, enable, global set
// [R18] software avoids read-modify-write on control register
// [R19] divider field: 2,2,4,8,16,32,64,128
// [R20] prescaler held reset while enable low
// [R21] normal 13 cycles, first after enable 25
// [R22] free-run restarts at completion; single clears start
// [R23] result presented with flag, aligned per left-align
`ifndef ACV_MAP_SVH
`define ACV_MAP_SVH
`define ACV_OFS_CTRL     3'h6
`define ACV_OFS_INSEL    3'h7
`define ACV_OFS_RES_LO   3'h4
`define ACV_OFS_RES_HI   3'h5
`define ACV_B_EN         7
`define ACV_B_START      6
`define ACV_B_FREE       5
`define ACV_B_FLAG       4
`define ACV_B_IE         3
`define ACV_B_ALIGN      5
`define ACV_RESET_BYTE   8'h00
`define ACV_CYC_NORMAL   5'h0D
`define ACV_CYC_EXT      5'h19
`define ACV_CODE_LAST_SE 5'h0A
`define ACV_CODE_BG      5'h1E
`define ACV_CODE_GND     5'h1F
`define ACV_IN_BG        4'hE
`define ACV_IN_GND       4'hF
`define ACV_IN_NONE      4'hF
`endif

// >>> pkg/acv_pkg.sv
`default_nettype none
package acv_pkg;
   typedef enum logic [1:0] {
      ACV_IDLE  = 2'h0,
      ACV_WAIT  = 2'h1,
      ACV_CONV  = 2'h3
   } acv_state_t;
   typedef enum logic [1:0] {
      ACV_REF_SUPPLY  = 2'h0,
      ACV_REF_PIN     = 2'h1,
      ACV_REF_INT     = 2'h2,
      ACV_REF_INT_CAP = 2'h3
   } acv_ref_t;
endpackage
`default_nettype wire

// >>> pkg/acv_pre_if.sv
`default_nettype none
interface acv_pre_if;
   logic       run;
   logic [2:0] div_sel;
   logic       tick;
   modport ctrl (output run, output div_sel, input tick);
   modport pre  (input run, input div_sel, output tick);
endinterface
`default_nettype wire

// >>> core/acv_prescaler.sv
`default_nettype none
module acv_prescaler
   import acv_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   acv_pre_if.pre    pre
);
   logic [6:0] cnt_q;
   logic [6:0] mask;
   // divide factor minus one; codes 0 and 1 both divide by two
   assign mask = (pre.div_sel == 3'h0) ? 7'h01
               : 7'((8'h01 << pre.div_sel) - 8'h01); // R19
   assign pre.tick = pre.run && ((cnt_q & mask) == mask);
   always_ff @(posedge clk_i) begin
      if (rst_i || !pre.run) begin
         cnt_q <= 7'h00; // R20
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end
endmodule
`default_nettype wire

// >>> core/acv_ctrl.sv
`include "acv_map.svh"
`default_nettype none
module acv_ctrl
   import acv_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   input  wire logic       global_irq_en_i,
   input  wire logic       vector_taken_i,
   input  wire logic [9:0] core_result_i,
   output logic            irq_o,
   output logic            core_power_o,
   output logic            core_clk_en_o,
   output logic            core_start_o,
   output logic            core_extended_o,
   output logic [1:0]      ref_sel_o,
   output logic [3:0]      pos_in_o,
   output logic [3:0]      neg_in_o,
   output logic            diff_o,
   output logic            gain20_o
);
   acv_pre_if pif ();
   acv_prescaler u_pre (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pre   (pif.pre)
   );

   // channel decode: {diff, gain20, pos, neg}
   function automatic logic [9:0] chan_decode(input logic [4:0] c);
      logic [9:0] r;
      r = {2'b00, 4'h0, `ACV_IN_NONE};
      if (c <= `ACV_CODE_LAST_SE) begin
         r = {2'b00, c[3:0], `ACV_IN_NONE}; // R6
      end else if (c == `ACV_CODE_BG) begin
         r = {2'b00, `ACV_IN_BG, `ACV_IN_NONE}; // R6
      end else if (c == `ACV_CODE_GND) begin
         r = {2'b00, `ACV_IN_GND, `ACV_IN_NONE}; // R6
      end else begin
         unique case (c) // R7
            5'h0B: r = {2'b11, 4'h0, 4'h1};
            5'h0C: r = {2'b10, 4'h0, 4'h1};
            5'h0D: r = {2'b11, 4'h1, 4'h1}; // R8
            5'h0E: r = {2'b11, 4'h2, 4'h1};
            5'h0F: r = {2'b10, 4'h2, 4'h1};
            5'h10: r = {2'b10, 4'h2, 4'h3};
            5'h11: r = {2'b11, 4'h3, 4'h3}; // R8
            5'h12: r = {2'b11, 4'h4, 4'h3};
            5'h13: r = {2'b10, 4'h4, 4'h3};
            5'h14: r = {2'b11, 4'h4, 4'h5};
            5'h15: r = {2'b10, 4'h4, 4'h5};
            5'h16: r = {2'b11, 4'h5, 4'h5}; // R8
            5'h17: r = {2'b11, 4'h6, 4'h5};
            5'h18: r = {2'b10, 4'h6, 4'h5};
            5'h19: r = {2'b11, 4'h8, 4'h9};
            5'h1A: r = {2'b10, 4'h8, 4'h9};
            5'h1B: r = {2'b11, 4'h9, 4'h9}; // R8
            5'h1C: r = {2'b11, 4'hA, 4'h9};
            5'h1D: r = {2'b10, 4'hA, 4'h9};
            default: r = {2'b00, `ACV_IN_GND, `ACV_IN_NONE};
         endcase
      end
      return r;
   endfunction

   logic       en_q, start_q, free_q, flag_q, ie_q, dummy_q, first_q;
   logic [2:0] div_q;
   logic [1:0] ref_q;
   logic       align_q;
   logic [4:0] chan_q;
   logic [1:0] ref_act_q;
   logic [4:0] chan_act_q;
   logic [9:0] result_q;
   logic [4:0] cyc_q;
   logic [7:0] rdata_q;
   logic       irq_q, start_pulse_q, ext_q;
   logic [9:0] dec_q;
   acv_state_t st_q;

   wire wr_ctrl  = wr_i && (addr_i == `ACV_OFS_CTRL);
   wire wr_insel = wr_i && (addr_i == `ACV_OFS_INSEL);
   wire en_new   = wr_ctrl ? wdata_i[`ACV_B_EN] : en_q;
   wire start_wr = wr_ctrl && wdata_i[`ACV_B_START]; // R13
   wire tick     = pif.tick;
   wire [4:0] last_cyc = dummy_q ? `ACV_CYC_EXT : `ACV_CYC_NORMAL; // R21
   // ticks elapsed since the conversion began, counting this one
   wire [4:0] cyc_nx = cyc_q + 5'h01;
   wire conv_end = (st_q == ACV_CONV) && tick && (cyc_nx == last_cyc);
   wire real_end = conv_end && !dummy_q;
   wire restart  = real_end && free_q; // R22
   wire busy     = (st_q != ACV_IDLE);
   // selection tracks register while idle and at each conversion end
   wire track    = !busy || conv_end; // R2

   assign pif.run     = en_q; // R20
   assign pif.div_sel = div_q; // R19

   wire [15:0] res_view = align_q ? {result_q, 6'h00}
                                  : {6'h00, result_q}; // R5
   wire [7:0] ctrl_view = {en_q, start_q, free_q, flag_q, ie_q, div_q};
   wire [7:0] insel_view = {ref_q, align_q, chan_q};
   wire [7:0] rd_mux = (addr_i == `ACV_OFS_CTRL)   ? ctrl_view
                     : (addr_i == `ACV_OFS_INSEL)  ? insel_view
                     : (addr_i == `ACV_OFS_RES_LO) ? res_view[7:0]
                     : (addr_i == `ACV_OFS_RES_HI) ? res_view[15:8]
                     : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= `ACV_RESET_BYTE;
      end else begin
         rdata_q <= rd_i ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {ref_q, align_q, chan_q} <= `ACV_RESET_BYTE;
      end else if (wr_insel) begin
         {ref_q, align_q, chan_q} <= wdata_i; // R1
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_act_q  <= 2'h0;
         chan_act_q <= 5'h00;
      end else if (track) begin
         ref_act_q  <= ref_q; // R2
         chan_act_q <= chan_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q  <= 1'b0;
         free_q <= 1'b0;
         ie_q  <= 1'b0;
         div_q <= 3'h0;
      end else if (wr_ctrl) begin
         en_q  <= wdata_i[`ACV_B_EN]; // R9
         free_q <= wdata_i[`ACV_B_FREE]; // R14
         ie_q  <= wdata_i[`ACV_B_IE];
         div_q <= wdata_i[2:0];
      end
   end

   // completion flag: set wins over both clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (real_end) begin
         flag_q <= 1'b1; // R15
      end else if (vector_taken_i
                   || (wr_ctrl && wdata_i[`ACV_B_FLAG])) begin
         flag_q <= 1'b0; // R16
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= 10'h000;
      end else if (real_end) begin
         result_q <= core_result_i; // R23
      end
   end

   // dummy pending until first start after enable
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_new) begin
         first_q <= 1'b1; // R11
      end else if (start_wr) begin
         first_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_new) begin
         st_q    <= ACV_IDLE; // R9
         start_q <= 1'b0;
         dummy_q <= 1'b0;
         cyc_q   <= 5'h00;
      end else begin
         unique case (st_q)
            ACV_IDLE: begin
               if (start_wr) begin
                  st_q    <= ACV_WAIT; // R10
                  start_q <= 1'b1; // R12
                  dummy_q <= first_q; // R11
               end
            end
            ACV_WAIT: begin
               if (tick) begin
                  st_q  <= ACV_CONV;
                  cyc_q <= 5'h00;
               end
            end
            ACV_CONV: begin
               if (tick) begin
                  if (conv_end) begin
                     cyc_q <= 5'h00;
                     if (dummy_q) begin
                        dummy_q <= 1'b0; // R12
                     end else if (!restart) begin
                        st_q    <= ACV_IDLE;
                        start_q <= 1'b0; // R22
                     end
                  end else begin
                     cyc_q <= cyc_nx; // R21
                  end
               end
            end
            default: st_q <= ACV_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q         <= 1'b0;
         start_pulse_q <= 1'b0;
         ext_q         <= 1'b0;
         // idle decode: no input on the negative terminal
         dec_q         <= {6'h00, `ACV_IN_NONE};
      end else begin
         irq_q <= flag_q && ie_q && global_irq_en_i; // R17
         start_pulse_q <= tick && ((st_q == ACV_WAIT) || conv_end);
         ext_q <= dummy_q;
         dec_q <= chan_decode(chan_act_q);
      end
   end

   assign rdata_o         = rdata_q;
   assign irq_o           = irq_q;
   assign core_power_o    = en_q;
   assign core_clk_en_o   = start_pulse_q;
   assign core_start_o    = start_pulse_q;
   assign core_extended_o = ext_q;
   assign ref_sel_o       = ref_act_q;
   assign diff_o          = dec_q[9];
   assign gain20_o        = dec_q[8];
   assign pos_in_o        = dec_q[7:4];
   assign neg_in_o        = dec_q[3:0];
endmodule
`default_nettype wire

// >>> testbench/acv_ctrl_properties.sv
`default_nettype none
module acv_ctrl_properties (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       global_irq_en_i,
   input wire logic       vector_taken_i,
   input wire logic       irq_o,
   input wire logic       core_power_o,
   input wire logic       core_start_o,
   input wire logic [1:0] ref_sel_o,
   input wire logic [3:0] pos_in_o,
   input wire logic [3:0] neg_in_o,
   input wire logic       diff_o,
   input wire logic       gain20_o
);
   wire [11:0] sel_w;
   assign sel_w = {ref_sel_o, pos_in_o, neg_in_o, diff_o, gain20_o};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_launch; core_start_o; endsequence
   sequence s_held; $stable(sel_w) [*5]; endsequence
   property p_lock; s_launch |-> ##3 s_held; endproperty
   property p_gap; s_launch |=> !core_start_o [*8]; endproperty
   property p_off; !core_power_o |-> !core_start_o; endproperty
   property p_irq; irq_o |-> $past(global_irq_en_i); endproperty
   property p_vec; vector_taken_i |-> ##2 !irq_o; endproperty
   property p_diff; diff_o |-> pos_in_o <= 4'hA && neg_in_o <= 4'hA;
   endproperty
   property p_single; !diff_o |-> !gain20_o && neg_in_o == 4'hF;
   endproperty
   property p_rdata; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_lock: assert property (p_lock)
      else $error("selection moved during conversion");
   a_gap: assert property (p_gap)
      else $error("conversion starts too close");
   a_off: assert property (p_off)
      else $error("conversion start while disabled");
   a_irq: assert property (p_irq)
      else $error("irq without global enable");
   a_vec: assert property (p_vec)
      else $error("irq kept after vector taken");
   a_diff: assert property (p_diff)
      else $error("differential input out of range");
   a_single: assert property (p_single)
      else $error("single-ended decode wrong");
   a_rdata: assert property (p_rdata)
      else $error("read data outside answer cycle");
endmodule
bind acv_ctrl acv_ctrl_properties u_acv_ctrl_properties (.*);
`default_nettype wire

// >>> testbench/acv_core_model.sv
`default_nettype none
module acv_core_model (
   input  wire logic       clk_i,
   input  wire logic       power_i,
   input  wire logic       start_i,
   input  wire logic [9:0] value_i,
   output logic      [9:0] result_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held_q;
   // scrambled while powered down
   assign result_o = power_i ? held_q : ~held_q;
   always_ff @(posedge clk_i) begin
      if (start_i) begin
         held_q <= value_i;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic       global_irq_en_i = 1'b0;
   logic       vector_taken_i = 1'b0;
   logic [9:0] val = 10'h000;
   logic [9:0] core_result_i;
   logic [7:0] rdata_o;
   logic       irq_o, core_power_o, core_clk_en_o, core_start_o;
   logic       core_extended_o, diff_o, gain20_o;
   logic [1:0] ref_sel_o;
   logic [3:0] pos_in_o, neg_in_o;
   logic [31:0] seed = 32'h41;
   logic [7:0] expq[$];
   logic       rd_d = 1'b0;
   int         errors = 0;
   int         checks = 0;
   int         n;
   logic [14:0] tab[9] = '{15'h2ABC, 15'h7BBC, 15'h7FFC, 15'h2C07,
      15'h3447, 15'h76A6, 15'h6196, 15'h44CF, 15'h003C};
   acv_ctrl u_acv_ctrl (.*);
   acv_core_model u_acv_core_model (.clk_i(clk_i), .power_i(core_power_o),
      .start_i(core_start_o), .value_i(val), .result_o(core_result_i));
   always #50 clk_i = ~clk_i;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      expq.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // cycles between two conversion starts
   task automatic meas(output int c);
      c = 0;
      do @(negedge clk_i); while (core_start_o !== 1'b1);
      do begin
         @(negedge clk_i);
         c++;
      end while (core_start_o !== 1'b1 && c < 9000);
      @(posedge clk_i);
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) rd_d <= rd_i;
   always @(negedge clk_i) begin
      if (rd_d) begin
         chk("rdata", {8'h00, expq.pop_front()}, {8'h00, rdata_o});
      end
   end
   initial begin
      #5_000_000;
      errors++;
      summarize();
   end
   initial begin : main
      logic [7:0] b;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      val <= 10'(xs());
      rd(3'h6, 8'h00);
      rd(3'h7, 8'h00);
      wr(3'h1, 8'hFF);
      rd(3'h1, 8'h00);
      b = 8'(xs());
      wr(3'h7, b);
      rd(3'h7, b);
      foreach (tab[i]) begin
         wr(3'h7, {2'(i), 1'b0, tab[i][14:10]});
         cyc(1);
         @(negedge clk_i);
         chk("sel", {4'h0, 2'(i), tab[i][9:0]}, 16'(u_sel()));
         @(posedge clk_i);
      end
      wr(3'h7, 8'h2B);
      for (int c = 7; c >= 0; c--) begin
         cyc(9);
         wr(3'h6, 8'h00);
         wr(3'h6, 8'hC8 | 8'(c));
         meas(n);
         chk("dummy", 16'(25 * (c == 0 ? 2 : 1 << c)), 16'(n));
      end
      global_irq_en_i <= 1'b1;
      wr(3'h7, 8'hEB);
      chk("ref", 16'h0, 16'(ref_sel_o));
      n = 0;
      while (irq_o !== 1'b1 && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk("irq", 16'h1, 16'(irq_o));
      cyc(3);
      chk("ref", 16'h3, 16'(ref_sel_o));
      rd(3'h6, 8'h98);
      rd(3'h5, val[9:2]);
      rd(3'h4, {val[1:0], 6'h00});
      wr(3'h7, 8'hCB);
      rd(3'h5, {6'h00, val[9:8]});
      rd(3'h4, val[7:0]);
      wr(3'h6, 8'h98);
      rd(3'h6, 8'h88);
      wr(3'h6, 8'hEB);
      meas(n);
      chk("free", 16'd104, 16'(n));
      wr(3'h6, 8'hAB);
      rd(3'h6, 8'hFB);
      vector_taken_i <= 1'b1;
      @(posedge clk_i);
      vector_taken_i <= 1'b0;
      rd(3'h6, 8'hEB);
      meas(n);
      chk("free", 16'd104, 16'(n));
      wr(3'h6, 8'h8B);
      cyc(120);
      rd(3'h6, 8'h9B);
      wr(3'h6, 8'h00);
      chk("power", 16'h0, 16'(core_power_o));
      summarize();
   end
   function automatic logic [11:0] u_sel();
      return {ref_sel_o, pos_in_o, neg_in_o, diff_o, gain20_o};
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire
